// ### include/lgp_defs.svh
// Purpose: Shared constants of the LED grayscale PWM link
// Assumes: mclk at 10 MHz on both ends
// Notes:   Times in ns, counts derived from them
`ifndef LGP_DEFS_SVH
`define LGP_DEFS_SVH

`define LGP_MCLK_NS         100
`define LGP_LATCH_MIN_NS    666
`define LGP_LATCH_MAX_NS    2740000
// Least time rounds up, longest time rounds down
`define LGP_LATCH_MIN_CYC   ((`LGP_LATCH_MIN_NS + `LGP_MCLK_NS - 1) / `LGP_MCLK_NS)
`define LGP_LATCH_MAX_CYC   (`LGP_LATCH_MAX_NS / `LGP_MCLK_NS)

`define LGP_PACKET_BITS     224
`define LGP_PACKET_LAST     8'hDF
`define LGP_CMD_HI          223
`define LGP_CMD_LO          218
`define LGP_WRITE_CMD       6'h25
`define LGP_GS_HI           191
`define LGP_BR_LO           192
`define LGP_BR_HI           212
`define LGP_FN_LO           213
`define LGP_FN_HI           217

`define LGP_FN_FORCE_OFF    0
`define LGP_FN_REPEAT       1
`define LGP_FN_TIMING_RST   2
`define LGP_FN_CLK_SEL      3
`define LGP_FN_EDGE_SEL     4
`define LGP_FN_RESET        5'h01

`define LGP_BR_RED_LO       0
`define LGP_BR_GREEN_LO     7
`define LGP_BR_BLUE_LO      14

`define LGP_CHANNELS        12
`define LGP_GS_MAX          16'hFFFF
`define LGP_OSC_HALF_CYC    8'h01
`define LGP_SCK_HALF_CYC    8'h02
// Host idle gap: above eight shift periods of four mclk cycles
`define LGP_HOST_GAP_CYC    16'h0028

`endif

// ### include/lgp_pkg.sv
// Purpose: Types of the LED grayscale PWM link
// Assumes: Constants come from lgp_defs.svh
// Notes:   Types only
package lgp_pkg;
  typedef logic [223:0] lgp_packet_type;
  typedef enum {PWM_OFF, PWM_WAIT, PWM_RUN, PWM_DONE} lgp_pwm_state_type;
  typedef enum {H_IDLE, H_LOW, H_HIGH, H_GAP} lgp_host_state_type;
endpackage

// ### include/lgp_link_if.sv
// Purpose: Two-wire shift link between host and driver
// Assumes: All wires synchronous to mclk
// Notes:   serialDataOut feeds the next driver of a chain
`timescale 1ns/10ps
`default_nettype none
interface lgp_link_if;
  logic serialShiftClock;
  logic serialDataIn;
  logic serialDataOut;
  modport host   (output serialShiftClock, output serialDataIn, input serialDataOut);
  modport device (input serialShiftClock, input serialDataIn, output serialDataOut);
endinterface
`default_nettype wire

// ### logic/lgp_host.sv
// Purpose: Host end, shifts packets and clock pulses to a driver chain
// Assumes: Shift clock made from mclk by a divider
// Notes:   One packet held ahead so packets follow with no gap
`timescale 1ns/10ps
`default_nettype none
`include "lgp_defs.svh"
module lgp_host
  import lgp_pkg::*;
(
  input  wire logic           mclk,
  input  wire logic           reset_n,
  lgp_link_if.host            link,
  input  wire lgp_packet_type packetData,
  input  wire logic           packetValid,
  output logic                packetReady,
  input  wire logic [15:0]    pulseCount,
  input  wire logic           pulseValid,
  output logic                busy,
  output logic                frameDone
);

  lgp_host_state_type state;
  lgp_packet_type     holdData;
  lgp_packet_type     sendReg;
  logic               holdFree;
  logic               sck;
  logic               sdo;
  logic               pulseMode;
  logic [7:0]         phase;
  logic [7:0]         bitsLeft;
  logic [15:0]        pulsesLeft;
  logic [15:0]        gapCount;
  logic               phaseEnd;
  logic               wordEnd;
  logic               loadNow;

  assign phaseEnd = phase == (`LGP_SCK_HALF_CYC - 8'h01);
  assign wordEnd  = (state == H_HIGH) && phaseEnd && !pulseMode && (bitsLeft == 8'h00);
  assign loadNow  = !holdFree && ((state == H_IDLE) || wordEnd);

  assign link.serialShiftClock = sck;
  assign link.serialDataIn     = sdo;
  assign packetReady           = holdFree;

  ////////////////////////////////////////////////////////////////////////
  // Holding register: next packet waits here so the chain sees no gap
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      holdFree <= 1'b1;
      holdData <= '0;
    end else if (loadNow) begin
      holdFree <= 1'b1;
    end else if (packetValid && holdFree) begin
      holdData <= packetData;
      holdFree <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shift sequencer, data changes while the clock is low
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state      <= H_IDLE;
      phase      <= 8'h00;
      sck        <= 1'b0;
      sdo        <= 1'b0;
      bitsLeft   <= 8'h00;
      sendReg    <= '0;
      pulseMode  <= 1'b0;
      pulsesLeft <= 16'h0000;
      gapCount   <= 16'h0000;
      busy       <= 1'b0;
      frameDone  <= 1'b0;
    end else begin
      frameDone <= 1'b0;
      case (state)
        H_IDLE: begin
          phase <= 8'h00;
          if (loadNow) begin
            sendReg   <= holdData;
            sdo       <= holdData[`LGP_PACKET_BITS-1];
            bitsLeft  <= `LGP_PACKET_LAST;
            pulseMode <= 1'b0;
            busy      <= 1'b1;
            state     <= H_LOW;
          end else if (pulseValid && (pulseCount != 16'h0000)) begin
            pulsesLeft <= pulseCount - 16'h0001;
            pulseMode  <= 1'b1;
            sdo        <= 1'b0;
            busy       <= 1'b1;
            state      <= H_LOW;
          end
        end
        H_LOW: begin
          if (phaseEnd) begin
            sck   <= 1'b1;
            phase <= 8'h00;
            state <= H_HIGH;
          end else begin
            phase <= phase + 8'h01;
          end
        end
        H_HIGH: begin
          if (!phaseEnd) begin
            phase <= phase + 8'h01;
          end else begin
            sck   <= 1'b0;
            phase <= 8'h00;
            if (pulseMode) begin
              if (pulsesLeft == 16'h0000) begin
                state     <= H_IDLE;
                busy      <= 1'b0;
                frameDone <= 1'b1;
              end else begin
                pulsesLeft <= pulsesLeft - 16'h0001;
                state      <= H_LOW;
              end
            end else if (bitsLeft == 8'h00) begin
              if (loadNow) begin
                sendReg  <= holdData;
                sdo      <= holdData[`LGP_PACKET_BITS-1];
                bitsLeft <= `LGP_PACKET_LAST;
                state    <= H_LOW;
              end else begin
                sdo      <= 1'b0;
                gapCount <= 16'h0000;
                state    <= H_GAP;
              end
            end else begin
              sendReg  <= {sendReg[`LGP_PACKET_BITS-2:0], 1'b0};
              sdo      <= sendReg[`LGP_PACKET_BITS-2];
              bitsLeft <= bitsLeft - 8'h01;
              state    <= H_LOW;
            end
          end
        end
        H_GAP: begin
          // Clock held low long enough for every driver to latch
          if (gapCount == (`LGP_HOST_GAP_CYC - 16'h0001)) begin
            state     <= H_IDLE;
            busy      <= 1'b0;
            frameDone <= 1'b1;
          end else begin
            gapCount <= gapCount + 16'h0001;
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end

endmodule // lgp_host
`default_nettype wire

// ### logic/lgp_device.sv
// Purpose: Twelve-channel grayscale PWM driver with cascadable shift input
// Assumes: Link pins synchronous to mclk; oscillator modelled by an mclk divider
// Notes:   Outputs are digital on/off levels; current sinks are outside
//
// Functional notes
// - Blue brightness from packet bits 212..206
// - Force-off blanks outputs, clears counter, reinitialises
// - Force-off clear lets PWM drive outputs
// - Force-off is set after reset
// - Repeat off: one display period per start
// - Repeat on: period restarts every 65536 clocks
// - Timing-reset latch pulse clears counter, blanks outputs
// - Timing-reset off: latch pulse leaves PWM alone unless force-off is set or newly cleared
// - Restart from next reference clock rising edge
// - Clock select: oscillator or shift clock
// - Edge select: rising when 1, falling when 0
// - Latch pulse after idle of 8x interval
// - Idle timeout clamped between 666 ns, 2.74 ms
// - Packet is 224 bits with fixed fields
// - Host resends whole chain on any change
// - Host sends MSB first, farthest device first
// - Latch copies 218 bits only on command 25h
// - Latch loads data; starts PWM only with timing reset or force-off clear
// - Host sets oscillator mode, repeat, force-off clear
// - Repeat continues only while reference clock runs
// - Red and green brightness fields
// - Twelve 16-bit grayscale values, red first
`timescale 1ns/10ps
`default_nettype none
`include "lgp_defs.svh"
module lgp_device
  import lgp_pkg::*;
#(
  parameter int LATCH_MAX_CYC = `LGP_LATCH_MAX_CYC
)(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  lgp_link_if.device       link,
  output logic [11:0]      ledOutput,
  output logic [6:0]       redGroupBrightness,
  output logic [6:0]       greenGroupBrightness,
  output logic [6:0]       blueGroupBrightness,
  output logic             latchStrobe
);

  localparam logic [22:0] MAX_L = 23'(LATCH_MAX_CYC);
  localparam logic [22:0] MIN_L = 23'(`LGP_LATCH_MIN_CYC);

  function automatic logic [15:0] gsOf(input logic [191:0] gs, input int ch);
    gsOf = gs[16*ch +: 16];
  endfunction

  lgp_packet_type    shiftReg;
  logic              sckPrev;
  logic              sckRise;
  logic              sckFall;
  logic [22:0]       sinceEdge;
  logic [22:0]       interval;
  logic [22:0]       scaled;
  logic [22:0]       limit;
  logic              armed;
  logic              idleHit;
  logic              latchFire;
  logic [191:0]      gsLatch;
  logic [20:0]       brLatch;
  logic [4:0]        fnBits;
  logic [4:0]        newFn;
  logic [7:0]        oscCount;
  logic              oscPhase;
  logic              oscTick;
  logic              refRise;
  logic              refFall;
  logic              outEdge;
  logic              blankEvt;
  logic              startEvt;
  lgp_pwm_state_type pwmState;
  logic [15:0]       gsCount;
  logic [11:0]       next_ledOutput;

  ////////////////////////////////////////////////////////////////////////
  // Shift register and cascade output
  assign sckRise = link.serialShiftClock & ~sckPrev;
  assign sckFall = ~link.serialShiftClock & sckPrev;
  assign link.serialDataOut = shiftReg[`LGP_PACKET_BITS-1];

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sckPrev  <= 1'b0;
      shiftReg <= '0;
    end else begin
      sckPrev <= link.serialShiftClock;
      if (sckRise) begin
        shiftReg <= {shiftReg[`LGP_PACKET_BITS-2:0], link.serialDataIn};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Idle detector for the internal latch pulse
  // Interval is the spacing of the last two rising edges in mclk cycles
  assign scaled  = (interval > (MAX_L >> 3)) ? MAX_L : {interval[19:0], 3'b000};
  assign limit   = (scaled < MIN_L) ? MIN_L : scaled;
  assign idleHit = armed && !sckRise && (sinceEdge >= limit);
  assign latchFire = idleHit && (shiftReg[`LGP_CMD_HI:`LGP_CMD_LO] == `LGP_WRITE_CMD);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sinceEdge <= 23'h00_0000;
      interval  <= 23'h00_0000;
      armed     <= 1'b0;
    end else if (sckRise) begin
      sinceEdge <= 23'h00_0000;
      interval  <= sinceEdge + 23'h00_0001;
      armed     <= 1'b1;
    end else begin
      if (sinceEdge < MAX_L) begin
        sinceEdge <= sinceEdge + 23'h00_0001;
      end
      // One pulse per idle stretch, even when the command was wrong
      if (idleHit) begin
        armed <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data latch
  assign newFn = shiftReg[`LGP_FN_HI:`LGP_FN_LO];
  assign redGroupBrightness   = brLatch[`LGP_BR_RED_LO +: 7];
  assign greenGroupBrightness = brLatch[`LGP_BR_GREEN_LO +: 7];
  assign blueGroupBrightness  = brLatch[`LGP_BR_BLUE_LO +: 7];

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      gsLatch     <= '0;
      brLatch     <= '0;
      fnBits      <= `LGP_FN_RESET;
      latchStrobe <= 1'b0;
    end else begin
      latchStrobe <= latchFire;
      if (latchFire) begin
        gsLatch <= shiftReg[`LGP_GS_HI:0];
        brLatch <= shiftReg[`LGP_BR_HI:`LGP_BR_LO];
        fnBits  <= newFn;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Grayscale reference clock
  assign oscTick = oscCount == (`LGP_OSC_HALF_CYC - 8'h01);
  assign refRise = fnBits[`LGP_FN_CLK_SEL] ? sckRise : (oscTick && !oscPhase);
  assign refFall = fnBits[`LGP_FN_CLK_SEL] ? sckFall : (oscTick && oscPhase);
  assign outEdge = fnBits[`LGP_FN_EDGE_SEL] ? refRise : refFall;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      oscCount <= 8'h00;
      oscPhase <= 1'b0;
    end else if (oscTick) begin
      oscCount <= 8'h00;
      oscPhase <= ~oscPhase;
    end else begin
      oscCount <= oscCount + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // PWM timing controller
  // New force-off set wins over any start in the same latch
  assign blankEvt = latchFire && newFn[`LGP_FN_FORCE_OFF];
  assign startEvt = latchFire && !newFn[`LGP_FN_FORCE_OFF] &&
                    (fnBits[`LGP_FN_FORCE_OFF] || newFn[`LGP_FN_TIMING_RST]);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pwmState <= PWM_OFF;
      gsCount  <= 16'h0000;
    end else if (blankEvt) begin
      pwmState <= PWM_OFF;
      gsCount  <= 16'h0000;
    end else if (startEvt) begin
      pwmState <= PWM_WAIT;
      gsCount  <= 16'h0000;
    end else begin
      case (pwmState)
        PWM_OFF: gsCount <= 16'h0000;
        PWM_WAIT: begin
          if (refRise) begin
            pwmState <= PWM_RUN;
            gsCount  <= 16'h0000;
          end
        end
        PWM_RUN: begin
          // Without reference edges the period simply stalls
          if (refRise) begin
            if (gsCount == `LGP_GS_MAX) begin
              gsCount <= 16'h0000;
              if (!fnBits[`LGP_FN_REPEAT]) begin
                pwmState <= PWM_DONE;
              end
            end else begin
              gsCount <= gsCount + 16'h0001;
            end
          end
        end
        PWM_DONE: gsCount <= 16'h0000;
        default: pwmState <= PWM_OFF;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output compare, one comparator per channel
  // Compare uses the count before this edge, so in rising-edge mode outputs lag one reference edge
  genvar ch;
  generate
    for (ch = 0; ch < `LGP_CHANNELS; ch = ch + 1) begin : g_chan
      assign next_ledOutput[ch] = (pwmState == PWM_RUN) && (gsCount < gsOf(gsLatch, ch));
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ledOutput <= 12'h000;
    end else if (blankEvt || startEvt || (pwmState == PWM_OFF) || (pwmState == PWM_WAIT)) begin
      ledOutput <= 12'h000;
    end else if (outEdge) begin
      ledOutput <= next_ledOutput;
    end
  end

endmodule // lgp_device
`default_nettype wire

// ### dv/lgp_link_props.sv
// Purpose: Link and output checks for the LED grayscale PWM link
// Assumes: One mclk domain, reset_n synchronous active low
// Notes:   Sees the link wires and the driver outputs only
`timescale 1ns/10ps
`default_nettype none
module lgp_link_props (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        serialShiftClock,
  input wire logic        serialDataIn,
  input wire logic        serialDataOut,
  input wire logic [11:0] ledOutput,
  input wire logic [6:0]  blueGroupBrightness,
  input wire logic        latchStrobe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////
  logic       latched;
  logic       sckPrev;
  logic [7:0] quiet;
  always_ff @(posedge mclk) begin
    if (!reset_n)
      latched <= 1'b0;
    else if (latchStrobe)
      latched <= 1'b1;
  end
  // Saturates so a long idle never wraps back under the bound
  always_ff @(posedge mclk) begin
    sckPrev <= serialShiftClock;
    if (!reset_n || (serialShiftClock && !sckPrev))
      quiet <= 8'h00;
    else if (quiet != 8'hFF)
      quiet <= quiet + 8'h01;
  end
  ////////////////////////////////////////////////////////////
  AST_DARK_UNTIL_LATCH: assert property (!latched |-> ledOutput == 12'h000)
    else $error("outputs on before any latch");
  AST_STROBE_ONE_CYCLE: assert property (latchStrobe |=> !latchStrobe)
    else $error("latch strobe longer than one cycle");
  AST_LATCH_AFTER_IDLE: assert property (latchStrobe |-> quiet >= 8'h07)
    else $error("latch without idle shift clock");
  AST_BRIGHT_ON_LATCH: assert property ($changed(blueGroupBrightness) |-> ##[0:1] latchStrobe)
    else $error("brightness changed without latch");
  AST_SHIFT_ON_RISE: assert property ($changed(serialDataOut) |-> $past(serialShiftClock)
    && !$past(serialShiftClock, 2))
    else $error("chain output moved without a clock rise");
  AST_DATA_WHILE_LOW: assert property ($changed(serialDataIn) |-> !serialShiftClock)
    else $error("data changed while shift clock high");
  AST_SCK_HIGH_TWO: assert property ($rose(serialShiftClock) |-> serialShiftClock[*2] ##1 !serialShiftClock)
    else $error("shift clock high phase wrong");
  AST_SCK_LOW_TWO: assert property ($fell(serialShiftClock) |-> !serialShiftClock[*2])
    else $error("shift clock low phase too short");
  cover property (latchStrobe);
  cover property (ledOutput != 12'h000);
  cover property ($rose(serialShiftClock) ##4 $rose(serialShiftClock));
endmodule // lgp_link_props
`default_nettype wire

// ### dv/tb.sv
// Purpose: Host and driver joined on one link, checked end to end
// Assumes: Latch ceiling shortened to keep the run short
// Notes:   Brightness checked at each latch strobe from a queue
`timescale 1ns/10ps
`default_nettype none
`include "lgp_defs.svh"
module tb;
  import lgp_pkg::*;
  logic           mclk;
  logic           reset_n;
  lgp_packet_type packetData;
  logic           packetValid;
  logic           packetReady;
  logic [15:0]    pulseCount;
  logic           pulseValid;
  logic           busy;
  logic           frameDone;
  logic [11:0]    ledOutput;
  logic [6:0]     redB;
  logic [6:0]     greenB;
  logic [6:0]     blueB;
  logic           latchStrobe;
  logic [31:0]    seed;
  logic [20:0]    expQ[$];
  int             badCount;
  int             nTests;
  logic [11:0]    m;
  lgp_link_if link ();
  lgp_host lgp_host_i (.mclk(mclk), .reset_n(reset_n), .link(link), .packetData(packetData),
    .packetValid(packetValid), .packetReady(packetReady), .pulseCount(pulseCount),
    .pulseValid(pulseValid), .busy(busy), .frameDone(frameDone));
  // Short ceiling: the idle timeout on a slow link is clamped here
  lgp_device #(.LATCH_MAX_CYC(200)) lgp_device_i (.mclk(mclk), .reset_n(reset_n), .link(link),
    .ledOutput(ledOutput), .redGroupBrightness(redB), .greenGroupBrightness(greenB),
    .blueGroupBrightness(blueB), .latchStrobe(latchStrobe));
  lgp_link_props lgp_link_props_i (.mclk(mclk), .reset_n(reset_n),
    .serialShiftClock(link.serialShiftClock), .serialDataIn(link.serialDataIn),
    .serialDataOut(link.serialDataOut), .ledOutput(ledOutput), .blueGroupBrightness(blueB),
    .latchStrobe(latchStrobe));
  ////////////////////////////////////////////////////////////
  always #50 mclk = ~mclk;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic closeOut();
    $display("Checks %0d, mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic waitDone();
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (frameDone !== 1'b1 && k < 3000);
    chk({31'h0, frameDone}, 32'h1);
  endtask
  // Gray levels are all or nothing so the output state is known at any count
  task automatic send(input logic [5:0] cmd, input logic [4:0] fn, input logic [11:0] mask);
    logic [31:0]    r;
    lgp_packet_type pk;
    r = rnd();
    for (int c = 0; c < 12; c++) begin
      pk[16*c +: 16] = mask[c] ? 16'hFFFF : 16'h0000;
    end
    pk[223:192] = {cmd, fn, r[20:0]};
    if (cmd == 6'h25) begin
      expQ.push_back(r[20:0]);
    end
    @(posedge mclk);
    packetData  <= pk;
    packetValid <= 1'b1;
    do @(posedge mclk); while (packetReady !== 1'b1);
    packetValid <= 1'b0;
    waitDone();
  endtask
  task automatic pulses(input logic [15:0] n);
    @(posedge mclk);
    pulseCount <= n;
    pulseValid <= 1'b1;
    do @(posedge mclk); while (busy !== 1'b1);
    pulseValid <= 1'b0;
    waitDone();
  endtask
  ////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    if (reset_n && latchStrobe === 1'b1) begin
      if (expQ.size() == 0)
        chk(32'h1, 32'h0);
      else
        chk({11'h0, blueB, greenB, redB}, {11'h0, expQ.pop_front()});
    end
  end
  initial begin
    repeat (40000) @(posedge mclk);
    badCount++;
    closeOut();
  end
  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    packetData = '0;
    packetValid = 1'b0;
    pulseCount = 16'h0000;
    pulseValid = 1'b0;
    badCount = 0;
    nTests = 0;
    seed = 32'h0000_005E;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    chk({20'h0, ledOutput}, 32'h0);
    for (int i = 0; i < 2; i++) begin
      m = 12'(rnd());
      send(6'h25, 5'b10010, m);
      repeat (20) @(posedge mclk);
      chk({20'h0, ledOutput}, {20'h0, m});
      chk({31'h0, link.serialDataOut}, 32'h1);
    end
    // Wrong command with blanking set must leave the outputs running
    send(6'h25 ^ {m[4:0], 1'b1}, 5'b10011, ~m);
    repeat (20) @(posedge mclk);
    chk({20'h0, ledOutput}, {20'h0, m});
    for (int e = 1; e >= 0; e--) begin
      m = 12'(rnd());
      send(6'h25, {e[0], 4'b1100}, m);
      repeat (5) @(posedge mclk);
      chk({20'h0, ledOutput}, 32'h0);
      // One pulse: falling-edge mode already shows data, rising-edge mode waits a rise
      pulses(16'h0001);
      repeat (2) @(posedge mclk);
      chk({20'h0, ledOutput}, e ? 32'h0 : {20'h0, m});
      pulses(16'h0003);
      chk({20'h0, ledOutput}, {20'h0, m});
    end
    send(6'h25, 5'b10011, 12'hFFF);
    repeat (20) @(posedge mclk);
    chk({20'h0, ledOutput}, 32'h0);
    chk(expQ.size(), 32'h0);
    closeOut();
  end
endmodule // tb
`default_nettype wire
